//--- hdl/dtc_consts.vh
// Constants for the dual timer control block: register addresses,
// field positions, reset values and mode encodings.
// Included by the timer control design file.
`ifndef DTC_CONSTS_VH
`define DTC_CONSTS_VH
`define DTC_ADDR_CTRL 8'h88
`define DTC_ADDR_MODE 8'h89
`define DTC_ADDR_T0_LOW 8'h8A
`define DTC_ADDR_T1_LOW 8'h8B
`define DTC_ADDR_T0_HIGH 8'h8C
`define DTC_ADDR_T1_HIGH 8'h8D
`define DTC_CTRL_RESET 8'h00
`define DTC_MODE_RESET 8'h00
`define DTC_BIT_T1_OVF 7
`define DTC_BIT_T1_RUN 6
`define DTC_BIT_T0_OVF 5
`define DTC_BIT_T0_RUN 4
`define DTC_BIT_IRQ1_FLAG 3
`define DTC_BIT_IRQ1_TYPE 2
`define DTC_BIT_IRQ0_FLAG 1
`define DTC_BIT_IRQ0_TYPE 0
`define DTC_BIT_T1_GATE 7
`define DTC_BIT_T1_CSEL 6
`define DTC_BIT_T0_GATE 3
`define DTC_BIT_T0_CSEL 2
`define DTC_MODE_13BIT 2'h0
`define DTC_MODE_16BIT 2'h1
`define DTC_MODE_RELOAD 2'h2
`define DTC_MODE_SPLIT 2'h3
`endif

//--- hdl/dtc_timer_ctrl.v
// Two 8051-style counter/timers with their control and mode registers.
// Assumes a simple synchronous SFR bus on i_ref_clk and async pins.
// Overview of operation
// [RULE1] Timer 0 overflow sets its overflow flag in every mode.
// [RULE2] Software writing zero clears the timer 0 overflow flag.
// [RULE3] Vectoring to the timer 0 service routine clears its flag.
// [RULE4] Flag reads 0 until an overflow, then 1.
// [RULE5] With gate set, timer 1 counts only when run bit and pin high. With timer 0 in mode 3 the code ignores run bit and gate.
// [RULE6] Mode 2 is an 8-bit counter with automatic reload.
// [RULE7] Low byte wrap sets flag and reloads from unchanged high byte.
// [RULE8] Setting run bit keeps count values; counting resumes from them.
// [RULE9] In mode 3 timer 0 high byte uses timer 1 run bit and flag.
// [RULE10] Both control registers reset to zero: stopped, 13-bit, flags clear.
`timescale 1ns/1ps
`include "dtc_consts.vh"
module dtc_timer_ctrl (
  input wire i_ref_clk,
  input wire i_reset_n,
  input wire [7:0] i_sfr_addr,
  input wire i_sfr_wr,
  input wire i_sfr_rd,
  input wire [7:0] i_sfr_wdata,
  output reg [7:0] o_sfr_rdata,
  input wire i_t0_vector_ack,
  input wire i_t1_vector_ack,
  input wire i_irq0_vector_ack,
  input wire i_irq1_vector_ack,
  input wire i_ext_irq0_pin_n,
  input wire i_ext_irq1_pin_n,
  input wire i_t0_count_pin,
  input wire i_t1_count_pin,
  input wire i_timebase_tick,
  output wire o_t0_irq_req,
  output wire o_t1_irq_req,
  output wire o_irq0_req,
  output wire o_irq1_req,
  output reg o_t1_overflow_pulse
);
  reg [7:0] timer_control_flags;
  reg [7:0] timer_mode_config;
  reg [7:0] t0_count_low;
  reg [7:0] t0_count_high;
  reg [7:0] t1_count_low;
  reg [7:0] t1_count_high;
  reg [1:0] irq0_sync;
  reg [1:0] irq1_sync;
  reg [1:0] t0p_sync;
  reg [1:0] t1p_sync;
  reg irq0_prev;
  reg irq1_prev;
  reg t0p_prev;
  reg t1p_prev;
  reg [7:0] next_t0_low;
  reg [7:0] next_t0_high;
  reg [7:0] next_t1_low;
  reg [7:0] next_t1_high;
  reg t0_ovf;
  reg t0h_ovf;
  reg t1_ovf;
  reg [12:0] cnt13;
  reg [16:0] cnt16;
  reg [8:0] cnt8;
  wire ctrl_wr = i_sfr_wr && (i_sfr_addr == `DTC_ADDR_CTRL);
  wire [1:0] t0_mode = timer_mode_config[1:0];
  wire [1:0] t1_mode = timer_mode_config[5:4];
  wire t0_split = (t0_mode == `DTC_MODE_SPLIT);
  wire irq0_lvl = irq0_sync[1];
  wire irq1_lvl = irq1_sync[1];
  // Count pins sample falling edges after synchronising
  wire t0_pin_fall = t0p_prev && !t0p_sync[1];
  wire t1_pin_fall = t1p_prev && !t1p_sync[1];
  wire t0_tick = timer_mode_config[`DTC_BIT_T0_CSEL] ? t0_pin_fall : i_timebase_tick;
  // Mode 3 on timer 0 blocks external clocking of timer 1
  wire t1_tick = (timer_mode_config[`DTC_BIT_T1_CSEL] && !t0_split) ? t1_pin_fall : i_timebase_tick;
  // Gate: run bit alone, or run bit and pin high
  // Timer 0 gate lives in the mode register, not beside the irq flags
  wire t0_en = timer_control_flags[`DTC_BIT_T0_RUN] &&
               (!timer_mode_config[`DTC_BIT_T0_GATE] || irq0_lvl);
  wire t1_en = timer_control_flags[`DTC_BIT_T1_RUN] &&
               (!timer_mode_config[`DTC_BIT_T1_GATE] || irq1_lvl); // see [RULE5]
  // In split mode timer 1 runs unless its own mode is 3
  wire t1_run = t0_split ? (t1_mode != `DTC_MODE_SPLIT) : t1_en;
  wire t0h_run = timer_control_flags[`DTC_BIT_T1_RUN] && i_timebase_tick; // see [RULE9]
  wire irq0_fall = irq0_prev && !irq0_lvl;
  wire irq1_fall = irq1_prev && !irq1_lvl;

  // Pin synchronisers and edge history
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq0_sync <= 2'h3;
      irq1_sync <= 2'h3;
      t0p_sync <= 2'h3;
      t1p_sync <= 2'h3;
      irq0_prev <= 1'b1;
      irq1_prev <= 1'b1;
      t0p_prev <= 1'b1;
      t1p_prev <= 1'b1;
    end else begin
      irq0_sync <= {irq0_sync[0], i_ext_irq0_pin_n};
      irq1_sync <= {irq1_sync[0], i_ext_irq1_pin_n};
      t0p_sync <= {t0p_sync[0], i_t0_count_pin};
      t1p_sync <= {t1p_sync[0], i_t1_count_pin};
      irq0_prev <= irq0_sync[1];
      irq1_prev <= irq1_sync[1];
      t0p_prev <= t0p_sync[1];
      t1p_prev <= t1p_sync[1];
    end
  end

  // Next count values; no reset on run, values simply advance
  always @* begin
    next_t0_low = t0_count_low;
    next_t0_high = t0_count_high;
    next_t1_low = t1_count_low;
    next_t1_high = t1_count_high;
    t0_ovf = 1'b0;
    t0h_ovf = 1'b0;
    t1_ovf = 1'b0;
    cnt13 = 13'h0000;
    cnt16 = 17'h00000;
    cnt8 = 9'h000;
    if (t0_en && t0_tick) begin // see [RULE8]
      case (t0_mode)
        `DTC_MODE_13BIT: begin
          cnt13 = {t0_count_high, t0_count_low[4:0]} + 13'h0001;
          next_t0_high = cnt13[12:5];
          next_t0_low = {t0_count_low[7:5], cnt13[4:0]};
          t0_ovf = (cnt13 == 13'h0000);
        end
        `DTC_MODE_16BIT: begin
          cnt16 = {1'b0, t0_count_high, t0_count_low} + 17'h00001;
          {next_t0_high, next_t0_low} = cnt16[15:0];
          t0_ovf = cnt16[16];
        end
        `DTC_MODE_RELOAD: begin // see [RULE6]
          cnt8 = {1'b0, t0_count_low} + 9'h001;
          t0_ovf = cnt8[8];
          next_t0_low = cnt8[8] ? t0_count_high : cnt8[7:0]; // see [RULE7]
        end
        default: begin
          cnt8 = {1'b0, t0_count_low} + 9'h001;
          t0_ovf = cnt8[8];
          next_t0_low = cnt8[7:0];
        end
      endcase
    end
    // High byte of timer 0 is a separate timer in split mode
    if (t0_split && t0h_run) begin // see [RULE9]
      {t0h_ovf, next_t0_high} = {1'b0, t0_count_high} + 9'h001;
    end
    if (t1_run && t1_tick) begin
      case (t1_mode)
        `DTC_MODE_13BIT: begin
          cnt13 = {t1_count_high, t1_count_low[4:0]} + 13'h0001;
          next_t1_high = cnt13[12:5];
          next_t1_low = {t1_count_low[7:5], cnt13[4:0]};
          t1_ovf = (cnt13 == 13'h0000);
        end
        `DTC_MODE_16BIT: begin
          cnt16 = {1'b0, t1_count_high, t1_count_low} + 17'h00001;
          {next_t1_high, next_t1_low} = cnt16[15:0];
          t1_ovf = cnt16[16];
        end
        `DTC_MODE_RELOAD: begin // see [RULE6]
          cnt8 = {1'b0, t1_count_low} + 9'h001;
          t1_ovf = cnt8[8];
          next_t1_low = cnt8[8] ? t1_count_high : cnt8[7:0]; // see [RULE7]
        end
        default: begin
          // Mode 3 holds timer 1 still
        end
      endcase
    end
  end

  // Registers, counts and flags; hardware set wins over any clear
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      timer_control_flags <= `DTC_CTRL_RESET; // see [RULE10]
      timer_mode_config <= `DTC_MODE_RESET; // see [RULE10]
      t0_count_low <= 8'h00;
      t0_count_high <= 8'h00;
      t1_count_low <= 8'h00;
      t1_count_high <= 8'h00;
      o_t1_overflow_pulse <= 1'b0;
    end else begin
      o_t1_overflow_pulse <= t1_ovf;
      if (i_sfr_wr && i_sfr_addr == `DTC_ADDR_MODE)
        timer_mode_config <= i_sfr_wdata;
      t0_count_low <= (i_sfr_wr && i_sfr_addr == `DTC_ADDR_T0_LOW) ? i_sfr_wdata : next_t0_low;
      t0_count_high <= (i_sfr_wr && i_sfr_addr == `DTC_ADDR_T0_HIGH) ? i_sfr_wdata : next_t0_high;
      t1_count_low <= (i_sfr_wr && i_sfr_addr == `DTC_ADDR_T1_LOW) ? i_sfr_wdata : next_t1_low;
      t1_count_high <= (i_sfr_wr && i_sfr_addr == `DTC_ADDR_T1_HIGH) ? i_sfr_wdata : next_t1_high;
      if (ctrl_wr) begin
        timer_control_flags[`DTC_BIT_T1_RUN] <= i_sfr_wdata[`DTC_BIT_T1_RUN];
        timer_control_flags[`DTC_BIT_T0_RUN] <= i_sfr_wdata[`DTC_BIT_T0_RUN];
        timer_control_flags[`DTC_BIT_IRQ1_TYPE] <= i_sfr_wdata[`DTC_BIT_IRQ1_TYPE];
        timer_control_flags[`DTC_BIT_IRQ0_TYPE] <= i_sfr_wdata[`DTC_BIT_IRQ0_TYPE];
      end
      // Timer 0 flag: software write or vector clears, overflow sets
      if (t0_ovf)
        timer_control_flags[`DTC_BIT_T0_OVF] <= 1'b1; // see [RULE1], [RULE4]
      else if (i_t0_vector_ack)
        timer_control_flags[`DTC_BIT_T0_OVF] <= 1'b0; // see [RULE3]
      else if (ctrl_wr)
        timer_control_flags[`DTC_BIT_T0_OVF] <= i_sfr_wdata[`DTC_BIT_T0_OVF]; // see [RULE2]
      // Timer 1 flag owned by timer 0 high byte in split mode
      if (t0_split ? t0h_ovf : t1_ovf)
        timer_control_flags[`DTC_BIT_T1_OVF] <= 1'b1; // see [RULE9]
      else if (i_t1_vector_ack)
        timer_control_flags[`DTC_BIT_T1_OVF] <= 1'b0;
      else if (ctrl_wr)
        timer_control_flags[`DTC_BIT_T1_OVF] <= i_sfr_wdata[`DTC_BIT_T1_OVF];
      // Edge mode latches a fall; level mode follows the inverted pin
      if (!timer_control_flags[`DTC_BIT_IRQ0_TYPE])
        timer_control_flags[`DTC_BIT_IRQ0_FLAG] <= !irq0_lvl;
      else if (irq0_fall)
        timer_control_flags[`DTC_BIT_IRQ0_FLAG] <= 1'b1;
      else if (i_irq0_vector_ack)
        timer_control_flags[`DTC_BIT_IRQ0_FLAG] <= 1'b0;
      else if (ctrl_wr)
        timer_control_flags[`DTC_BIT_IRQ0_FLAG] <= i_sfr_wdata[`DTC_BIT_IRQ0_FLAG];
      if (!timer_control_flags[`DTC_BIT_IRQ1_TYPE])
        timer_control_flags[`DTC_BIT_IRQ1_FLAG] <= !irq1_lvl;
      else if (irq1_fall)
        timer_control_flags[`DTC_BIT_IRQ1_FLAG] <= 1'b1;
      else if (i_irq1_vector_ack)
        timer_control_flags[`DTC_BIT_IRQ1_FLAG] <= 1'b0;
      else if (ctrl_wr)
        timer_control_flags[`DTC_BIT_IRQ1_FLAG] <= i_sfr_wdata[`DTC_BIT_IRQ1_FLAG];
    end
  end

  // Registered read data; unmapped addresses read zero
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_rd) begin
      case (i_sfr_addr)
        `DTC_ADDR_CTRL: o_sfr_rdata <= timer_control_flags; // see [RULE4]
        `DTC_ADDR_MODE: o_sfr_rdata <= timer_mode_config;
        `DTC_ADDR_T0_LOW: o_sfr_rdata <= t0_count_low;
        `DTC_ADDR_T1_LOW: o_sfr_rdata <= t1_count_low;
        `DTC_ADDR_T0_HIGH: o_sfr_rdata <= t0_count_high;
        `DTC_ADDR_T1_HIGH: o_sfr_rdata <= t1_count_high;
        default: o_sfr_rdata <= 8'h00;
      endcase
    end
  end

  assign o_t0_irq_req = timer_control_flags[`DTC_BIT_T0_OVF];
  assign o_t1_irq_req = timer_control_flags[`DTC_BIT_T1_OVF];
  assign o_irq0_req = timer_control_flags[`DTC_BIT_IRQ0_FLAG];
  assign o_irq1_req = timer_control_flags[`DTC_BIT_IRQ1_FLAG];
endmodule // dtc_timer_ctrl

//--- bench/dtc_props.sv
// Port checker for the dual timer control block.
// Bound to dtc_timer_ctrl; sees its ports only.
`timescale 1ns/1ps
module dtc_props (
  input wire i_ref_clk,
  input wire i_reset_n,
  input wire [7:0] i_sfr_addr,
  input wire i_sfr_wr,
  input wire i_sfr_rd,
  input wire [7:0] i_sfr_wdata,
  input wire [7:0] o_sfr_rdata,
  input wire i_t0_vector_ack,
  input wire i_t1_vector_ack,
  input wire i_timebase_tick,
  input wire o_t0_irq_req,
  input wire o_t1_irq_req
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  // Control writes; quiet rules out a timebase tick racing a clear, not a pin-clocked count
  wire ctrl_wr = i_sfr_wr && i_sfr_addr == 8'h88;
  wire quiet = !i_timebase_tick;
  sequence mode_write;
    i_sfr_wr && i_sfr_addr == 8'h89;
  endsequence
  sequence mode_read;
    i_sfr_rd && !i_sfr_wr && i_sfr_addr == 8'h89;
  endsequence
  AST_RESET_CLEAR: assert property ($rose(i_reset_n) |-> !o_t0_irq_req && !o_t1_irq_req)
    else $error("flag set after reset");
  AST_T0_SW_SET: assert property (ctrl_wr && i_sfr_wdata[5] |=> o_t0_irq_req)
    else $error("timer 0 flag not set by write");
  AST_T0_SW_CLEAR: assert property (ctrl_wr && !i_sfr_wdata[5] && quiet |=> !o_t0_irq_req)
    else $error("timer 0 flag not cleared by write");
  AST_T0_ACK: assert property (i_t0_vector_ack && quiet && !ctrl_wr |=> !o_t0_irq_req)
    else $error("timer 0 flag not cleared by vectoring");
  AST_T0_HOLD: assert property (o_t0_irq_req && !i_t0_vector_ack && !ctrl_wr |=> o_t0_irq_req)
    else $error("timer 0 flag dropped");
  AST_T1_HOLD: assert property (o_t1_irq_req && !i_t1_vector_ack && !ctrl_wr |=> o_t1_irq_req)
    else $error("timer 1 flag dropped");
  AST_CTRL_READ: assert property (i_sfr_rd && i_sfr_addr == 8'h88 |=>
    o_sfr_rdata[5] == $past(o_t0_irq_req) && o_sfr_rdata[7] == $past(o_t1_irq_req))
    else $error("flag read differs from request line");
  AST_MODE_BACK: assert property (mode_write ##2 mode_read |=> o_sfr_rdata == $past(i_sfr_wdata, 3))
    else $error("mode register readback wrong");
endmodule // dtc_props
bind dtc_timer_ctrl dtc_props props_u (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_sfr_addr(i_sfr_addr),
  .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
  .i_t0_vector_ack(i_t0_vector_ack), .i_t1_vector_ack(i_t1_vector_ack), .i_timebase_tick(i_timebase_tick),
  .o_t0_irq_req(o_t0_irq_req), .o_t1_irq_req(o_t1_irq_req));

//--- bench/dtc_pin_model.sv
// Model of the external pin side: active-low interrupt/gate pins.
// The bench asks for low levels; pins idle high like pulled-up lines.
`timescale 1ns/1ps
module dtc_pin_model (
  input wire i_ref_clk,
  input wire [1:0] i_irq_low,
  input wire [1:0] i_cnt_run,
  output reg o_ext_irq0_pin_n = 1'b1,
  output reg o_ext_irq1_pin_n = 1'b1,
  output reg o_t0_count_pin = 1'b1,
  output reg o_t1_count_pin = 1'b1
);
  // Pins move after the falling edge, clear of the sampling edge
  // Count inputs toggle only while asked, else rest high so no stray fall
  always @(negedge i_ref_clk) begin
    o_ext_irq0_pin_n <= ~i_irq_low[0];
    o_ext_irq1_pin_n <= ~i_irq_low[1];
    o_t0_count_pin <= i_cnt_run[0] ? ~o_t0_count_pin : 1'b1;
    o_t1_count_pin <= i_cnt_run[1] ? ~o_t1_count_pin : 1'b1;
  end
endmodule // dtc_pin_model

//--- bench/tb_top.sv
// Self-checking bench for the dual timer control block.
// Drives the SFR bus and tick at the falling edge; pins via dtc_pin_model.
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  reg clk = 0, rst_n = 0, wr = 0, rd = 0, tick = 0, ack0 = 0;
  reg [7:0] addr = 0, wdata = 0, d, hv, lv;
  reg [1:0] low = 0;
  reg [1:0] cnt = 0;
  reg [31:0] rnd;
  integer err_total = 0, n_compared = 0, seed = 32'h5206, i;
  wire p0, p1, c0, c1, t0_req, t1_req;
  wire [7:0] rdata;
  dtc_pin_model pin_u (.i_ref_clk(clk), .i_irq_low(low), .i_cnt_run(cnt), .o_ext_irq0_pin_n(p0), .o_ext_irq1_pin_n(p1),
    .o_t0_count_pin(c0), .o_t1_count_pin(c1));
  dtc_timer_ctrl dut_u (.i_ref_clk(clk), .i_reset_n(rst_n), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd),
    .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_t0_vector_ack(ack0), .i_t1_vector_ack(1'b0),
    .i_irq0_vector_ack(1'b0), .i_irq1_vector_ack(1'b0), .i_ext_irq0_pin_n(p0), .i_ext_irq1_pin_n(p1),
    .i_t0_count_pin(c0), .i_t1_count_pin(c1), .i_timebase_tick(tick), .o_t0_irq_req(t0_req),
    .o_t1_irq_req(t1_req), .o_irq0_req(), .o_irq1_req(), .o_t1_overflow_pulse());
  // 40 MHz clock
  initial forever #12.5 clk = ~clk;
  // One SFR access; an idle cycle after keeps strobes from double assignment
  task acc(input w, input [7:0] a, input [7:0] v);
    wr = w;
    rd = !w;
    addr = a;
    wdata = v;
    @(negedge clk);
    wr = 0;
    rd = 0;
    @(negedge clk);
    d = rdata;
  endtask
  task conclude;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Bounded wait on a request line; running out ends the run
  task wait_req(input s, input integer lim);
    i = 0;
    while ((s ? t1_req : t0_req) !== 1'b1 && i < lim) begin
      @(negedge clk);
      i++;
    end
    if ((s ? t1_req : t0_req) !== 1'b1) begin
      err_total++;
      conclude;
    end
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1;
    acc(1'b0, 8'h88, 8'h00);
    `CHK(d, 8'h00)
    acc(1'b0, 8'h89, 8'h00);
    `CHK(d, 8'h00)
    // Auto-reload from a random high byte, start two below wrap
    rnd = $random(seed);
    hv = rnd[7:0];
    acc(1'b1, 8'h89, 8'h02);
    acc(1'b0, 8'h89, 8'h00);
    `CHK(d, 8'h02)
    acc(1'b1, 8'h8C, hv);
    acc(1'b1, 8'h8A, 8'hFE);
    tick = 1;
    acc(1'b1, 8'h88, 8'h10);
    wait_req(1'b0, 20);
    acc(1'b0, 8'h8C, 8'h00);
    `CHK(d, hv)
    acc(1'b0, 8'h88, 8'h00);
    `CHK(d[5], 1'b1)
    tick = 0;
    acc(1'b1, 8'h88, 8'h00);
    acc(1'b0, 8'h88, 8'h00);
    `CHK(d[5], 1'b0)
    // Software may raise the flag too; no tick, so nothing races it
    acc(1'b1, 8'h88, 8'h20);
    acc(1'b0, 8'h88, 8'h00);
    `CHK(d[5], 1'b1)
    acc(1'b1, 8'h88, 8'h00);
    // Run bit set with no ticks: count must be untouched
    rnd = $random(seed);
    lv = rnd[7:0];
    acc(1'b1, 8'h8A, lv);
    acc(1'b1, 8'h88, 8'h10);
    acc(1'b0, 8'h8A, 8'h00);
    `CHK(d, lv)
    tick = 1;
    wait_req(1'b0, 600);
    tick = 0;
    ack0 = 1;
    @(negedge clk);
    ack0 = 0;
    @(negedge clk);
    `CHK(t0_req, 1'b0)
    // Timer 1 gated by its pin, mode 2; pin pulled low one access before run
    acc(1'b1, 8'h88, 8'h00);
    acc(1'b1, 8'h89, 8'hA0);
    low = 2'b10;
    acc(1'b1, 8'h8B, 8'hF0);
    tick = 1;
    acc(1'b1, 8'h88, 8'h40);
    repeat (40) @(negedge clk);
    `CHK(t1_req, 1'b0)
    low = 2'b00;
    wait_req(1'b1, 100);
    `CHK(t1_req, 1'b1)
    // Split mode: timer 1 still runs and wraps but may not raise its flag
    tick = 0;
    acc(1'b1, 8'h88, 8'h00);
    acc(1'b1, 8'h89, 8'h23);
    acc(1'b1, 8'h8B, 8'hF0);
    acc(1'b1, 8'h8C, 8'hF8);
    tick = 1;
    repeat (40) @(negedge clk);
    `CHK(t1_req, 1'b0)
    acc(1'b1, 8'h88, 8'h40);
    wait_req(1'b1, 100);
    `CHK(t1_req, 1'b1)
    // Pin counting, 16-bit; gate clear so low pins and irq flags must not stop it
    tick = 0;
    acc(1'b1, 8'h88, 8'h00);
    low = 2'b11;
    acc(1'b1, 8'h89, 8'h05);
    acc(1'b1, 8'h8A, 8'hF8);
    acc(1'b1, 8'h8C, 8'hFF);
    cnt = 2'b01;
    acc(1'b1, 8'h88, 8'h10);
    wait_req(1'b0, 100);
    `CHK(t0_req, 1'b1)
    cnt = 2'b00;
    low = 2'b00;
    // Second reset in mid-run, with a flag and a run bit set
    rst_n = 0;
    @(negedge clk);
    rst_n = 1;
    `CHK(t0_req, 1'b0)
    acc(1'b0, 8'h88, 8'h00);
    `CHK(d, 8'h00)
    acc(1'b0, 8'h89, 8'h00);
    `CHK(d, 8'h00)
    conclude;
  end
endmodule // tb_top
